// ===== ldcb_config_bank.v
// Configuration word bank of the LED driver with decoded settings
`timescale 1ns/1ps
`include "ldcb_map.vh"

module ldcb_config_bank #(
   parameter CLK_MHZ = 20
)(
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rd_data_q,
   output reg rd_valid_q,
   input wire otp_emul_mode,
   input wire otp_write_mode,
   input wire init_mode,
   input wire general_input_0,
   input wire general_input_1,
   output wire [5:0] current_code_ch14,
   output wire [5:0] current_code_ch15,
   output wire [16:0] current_ch14_ua,
   output wire [16:0] current_ch15_ua,
   output wire [2:0] diag_filter_count,
   output wire low_power_during_init,
   output wire low_power_active,
   output wire [15:0] phase_delay_enable_n,
   output wire [3:0] pwm_base_rate,
   output wire [10:0] pwm_base_hz,
   output wire [9:0] phase_step_counts,
   output wire input0_duty_decode_en,
   output wire input1_duty_decode_en,
   output wire out0_regulator_feedback_en,
   output wire input1_effective,
   output wire outputs_enabled,
   output wire input0_analog_select,
   output wire input1_analog_select,
   output wire input0_pulldown_en,
   output wire input1_pulldown_en,
   output wire [14:0] diag_enable_thresh_supply_mv,
   output wire [14:0] diag_enable_thresh_led_mv,
   output wire [2:0] diag_sample_delay,
   output wire [9:0] diag_sample_delay_us,
   output wire [13:0] diag_sample_delay_cycles,
   output wire last_output_error_pin_en,
   output wire [15:0] adjacent_short_monitor_en,
   output wire [14:0] open_load_thresh_supply_mv,
   output wire [14:0] open_load_thresh_led_mv,
   output wire [15:0] anode_reference_select,
   output wire [15:0] input0_channel_mask,
   output wire [15:0] input1_channel_mask,
   output wire [15:0] channel_input_drive,
   output wire [15:0] channel_input_mapped,
   output wire watchdog_enabled,
   output wire [12:0] watchdog_timeout_ms,
   output wire [14:0] short_to_led_supply_thresh_mv,
   output wire short_to_led_supply_det_en
);

   // ==========================================
   // Conversion functions
   function [16:0] iset_ua;
      input [5:0] code;
      reg [33:0] prod;
      reg [33:0] quot;
      begin
         // Full code times span overflows 17 bits, so divide at full width
         prod = {28'h0000000, code} * {17'h00000, `LDCB_ISET_SPAN_UA};
         quot = prod / {17'h00000, `LDCB_ISET_MAX_CODE};
         // Quotient never exceeds the span, so the cut keeps every bit
         iset_ua = `LDCB_ISET_BASE_UA + quot[16:0];
      end
   endfunction

   function [14:0] scale_mv;
      input [7:0] code;
      input [14:0] step;
      reg [22:0] prod;
      begin
         prod = {15'h0000, code} * {8'h00, step};
         scale_mv = prod[14:0];
      end
   endfunction

   function [10:0] pwm_hz;
      input [3:0] code;
      begin
         // Rounded rates, as a host would quote them
         case (code)
            4'h0: pwm_hz = 11'h064;
            4'h1: pwm_hz = 11'h0C8;
            4'h2: pwm_hz = 11'h0F0;
            4'h3: pwm_hz = 11'h12C;
            4'h4: pwm_hz = 11'h168;
            4'h5: pwm_hz = 11'h190;
            4'h6: pwm_hz = 11'h21C;
            4'h7: pwm_hz = 11'h258;
            4'h8: pwm_hz = 11'h294;
            4'h9: pwm_hz = 11'h2D0;
            4'hA: pwm_hz = 11'h30C;
            4'hB: pwm_hz = 11'h384;
            4'hC: pwm_hz = 11'h4B0;
            4'hD: pwm_hz = 11'h5DC;
            4'hE: pwm_hz = 11'h708;
            default: pwm_hz = 11'h7D0;
         endcase
      end
   endfunction

   function [9:0] delay_us;
      input [2:0] code;
      begin
         case (code)
            3'h0: delay_us = 10'h008;
            3'h1: delay_us = 10'h010;
            3'h2: delay_us = 10'h018;
            3'h3: delay_us = 10'h030;
            3'h4: delay_us = 10'h060;
            3'h5: delay_us = 10'h0C0;
            3'h6: delay_us = 10'h12C;
            default: delay_us = 10'h258;
         endcase
      end
   endfunction

   function [12:0] wdt_ms;
      input [2:0] code;
      begin
         case (code)
            3'h1: wdt_ms = 13'h0014;
            3'h2: wdt_ms = 13'h0032;
            3'h3: wdt_ms = 13'h0064;
            3'h4: wdt_ms = 13'h00C8;
            3'h5: wdt_ms = 13'h01F4;
            3'h6: wdt_ms = 13'h03E8;
            3'h7: wdt_ms = 13'h07D0;
            default: wdt_ms = 13'h0000;
         endcase
      end
   endfunction

   // ==========================================
   // Storage
   reg [14:0] cur_dev_q;
   reg [15:0] phase_q;
   reg [15:0] pwm_in_q;
   reg [15:0] diag_td_q;
   reg [15:0] adj_q;
   reg [15:0] open_q;
   reg [15:0] anode_q;
   reg [15:0] map0_q;
   reg [15:0] map1_q;
   reg [15:0] wdt_q;
   reg [15:0] rd_data_d;
   wire prot_ok;
   wire [14:0] cur_dev_wr;
   reg [31:0] dly_prod;
   // Bit 15 of the first word is never stored, so its reset image drops it
   localparam [15:0] RST_CUR_DEV = `LDCB_RST_CUR_DEV;

   assign prot_ok = otp_emul_mode | otp_write_mode;
   // Only the low power bit is open to writes outside programming modes
   assign cur_dev_wr = prot_ok ? wdata[14:0] :
      {wdata[`LDCB_LOW_POWER_DURING_INIT_BIT], cur_dev_q[13:0]};

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cur_dev_q <= RST_CUR_DEV[14:0];
         phase_q <= `LDCB_RST_PHASE;
         pwm_in_q <= `LDCB_RST_PWM_IN;
         diag_td_q <= `LDCB_RST_DIAG_TD;
         adj_q <= `LDCB_RST_ADJ;
         open_q <= `LDCB_RST_OPEN;
         anode_q <= `LDCB_RST_ANODE;
         map0_q <= `LDCB_RST_MAP;
         map1_q <= `LDCB_RST_MAP;
         wdt_q <= `LDCB_RST_WDT;
      end
      else if (wr_en)
      begin
         if (addr == `LDCB_OFS_CUR_DEV)
            cur_dev_q <= cur_dev_wr;
         // Locked words drop the write with no sign to the host
         else if (prot_ok)
         begin
            case (addr)
               `LDCB_OFS_PHASE: phase_q <= wdata;
               `LDCB_OFS_PWM_IN: pwm_in_q <= wdata;
               `LDCB_OFS_DIAG_TD: diag_td_q <= wdata;
               `LDCB_OFS_ADJ: adj_q <= wdata;
               `LDCB_OFS_OPEN: open_q <= wdata;
               `LDCB_OFS_ANODE: anode_q <= wdata;
               `LDCB_OFS_MAP0: map0_q <= wdata;
               `LDCB_OFS_MAP1: map1_q <= wdata;
               `LDCB_OFS_DIAG: wdt_q <= wdata;
               default: cur_dev_q <= cur_dev_q;
            endcase
         end
      end
   end

   // ==========================================
   // Read path, one cycle after the request
   always @*
   begin
      case (addr)
         `LDCB_OFS_CUR_DEV: rd_data_d = {1'b0, cur_dev_q};
         `LDCB_OFS_PHASE: rd_data_d = phase_q;
         `LDCB_OFS_PWM_IN: rd_data_d = pwm_in_q;
         `LDCB_OFS_DIAG_TD: rd_data_d = diag_td_q;
         `LDCB_OFS_ADJ: rd_data_d = adj_q;
         `LDCB_OFS_OPEN: rd_data_d = open_q;
         `LDCB_OFS_ANODE: rd_data_d = anode_q;
         `LDCB_OFS_MAP0: rd_data_d = map0_q;
         `LDCB_OFS_MAP1: rd_data_d = map1_q;
         `LDCB_OFS_DIAG: rd_data_d = wdt_q;
         // Unmapped offsets read as zero, never as stale data
         default: rd_data_d = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         // Every read gets its valid pulse, mapped or not
         rd_valid_q <= rd_en;
         if (rd_en)
            rd_data_q <= rd_data_d;
      end
   end

   // ==========================================
   // Channel current and device settings
   assign current_code_ch14 = cur_dev_q[5:0];
   assign current_code_ch15 = cur_dev_q[11:6];
   assign current_ch14_ua = iset_ua(current_code_ch14);
   assign current_ch15_ua = iset_ua(current_code_ch15);
   // Reserved code 0 reports a count of zero rather than guessing
   assign diag_filter_count = {cur_dev_q[13:12], 1'b0};
   assign low_power_during_init = cur_dev_q[`LDCB_LOW_POWER_DURING_INIT_BIT];
   assign low_power_active = low_power_during_init & init_mode;

   // ==========================================
   // PWM timing
   // Stored bit 0 is kept for readback but never reaches the outputs
   assign phase_delay_enable_n = {phase_q[15:1], 1'b0};
   assign pwm_base_rate = pwm_in_q[3:0];
   assign pwm_base_hz = pwm_hz(pwm_base_rate);
   assign phase_step_counts = {1'b0, pwm_in_q[8:4]} * `LDCB_PHASE_STEP;

   // ==========================================
   // General input handling
   assign input0_duty_decode_en = pwm_in_q[`LDCB_DEC0_BIT];
   assign input1_duty_decode_en = pwm_in_q[`LDCB_DEC1_BIT];
   assign out0_regulator_feedback_en = pwm_in_q[`LDCB_FB_BIT];
   assign input1_effective =
      general_input_1 ^ pwm_in_q[`LDCB_INV1_BIT];
   assign outputs_enabled =
      ~pwm_in_q[`LDCB_GATE_BIT] | general_input_0;
   assign input0_analog_select = pwm_in_q[`LDCB_ANA0_BIT];
   assign input1_analog_select = pwm_in_q[`LDCB_ANA1_BIT];
   assign input0_pulldown_en = ~input0_analog_select;
   assign input1_pulldown_en = ~input1_analog_select;

   // ==========================================
   // Diagnostic thresholds and delay
   assign diag_enable_thresh_supply_mv =
      scale_mv({3'h0, diag_td_q[4:0]}, `LDCB_VDEN_STEP_MV);
   assign diag_enable_thresh_led_mv =
      scale_mv({3'h0, diag_td_q[9:5]}, `LDCB_VDEN_STEP_MV);
   assign diag_sample_delay = diag_td_q[12:10];
   assign diag_sample_delay_us = delay_us(diag_sample_delay);
   always @*
   begin
      // Longest delay times the clock rate still fits the 14-bit count
      dly_prod = {22'h000000, diag_sample_delay_us} * CLK_MHZ;
   end
   assign diag_sample_delay_cycles = dly_prod[13:0];
   // Mixed codes leave the pin function off, as a safe reading
   assign last_output_error_pin_en =
      (diag_td_q[15:13] == `LDCB_ERR_ON);
   assign adjacent_short_monitor_en = adj_q;
   assign open_load_thresh_supply_mv =
      scale_mv(open_q[7:0], `LDCB_OPEN_STEP_MV);
   assign open_load_thresh_led_mv =
      scale_mv(open_q[15:8], `LDCB_OPEN_STEP_MV);
   assign anode_reference_select = anode_q;

   // ==========================================
   // Input to channel mapping
   assign input0_channel_mask = map0_q;
   assign input1_channel_mask = map1_q;
   assign channel_input_mapped = map0_q | map1_q;
   // Second input drives its channels after the optional inversion
   assign channel_input_drive = (map0_q & {16{general_input_0}}) |
      (map1_q & {16{input1_effective}});

   // ==========================================
   // Watchdog and short detection
   assign watchdog_enabled = (wdt_q[2:0] != 3'h0);
   // Tripled timeout of the slowest code still fits 13 bits
   assign watchdog_timeout_ms = low_power_active ?
      wdt_ms(wdt_q[2:0]) * `LDCB_WDT_LP_MULT : wdt_ms(wdt_q[2:0]);
   assign short_to_led_supply_thresh_mv =
      scale_mv({4'h0, wdt_q[6:3]}, `LDCB_SHORT_STEP_MV);
   assign short_to_led_supply_det_en = (wdt_q[6:3] != 4'h0);

endmodule

// ===== ldcb_map.vh
// Register map, reset values and field positions of the configuration bank
`ifndef LDCB_MAP_VH
`define LDCB_MAP_VH

// ==========================================
// Word offsets
`define LDCB_OFS_CUR_DEV 8'h9B
`define LDCB_OFS_PHASE 8'h9C
`define LDCB_OFS_PWM_IN 8'h9D
`define LDCB_OFS_DIAG 8'hA4
`define LDCB_OFS_DIAG_TD 8'h9E
`define LDCB_OFS_ADJ 8'h9F
`define LDCB_OFS_OPEN 8'hA0
`define LDCB_OFS_ANODE 8'hA1
`define LDCB_OFS_MAP0 8'hA2
`define LDCB_OFS_MAP1 8'hA3

// ==========================================
// Reset values
`define LDCB_RST_CUR_DEV 16'h1820
`define LDCB_RST_PHASE 16'hFFFF
`define LDCB_RST_PWM_IN 16'h86F3
`define LDCB_RST_DIAG_TD 16'h09D0
`define LDCB_RST_ADJ 16'hFFFF
`define LDCB_RST_OPEN 16'h2020
`define LDCB_RST_ANODE 16'hFFFF
`define LDCB_RST_MAP 16'h0000
`define LDCB_RST_WDT 16'h0007

// ==========================================
// Field positions
`define LDCB_LOW_POWER_DURING_INIT_BIT 14
`define LDCB_RES_BIT 15
`define LDCB_DEC0_BIT 9
`define LDCB_DEC1_BIT 10
`define LDCB_FB_BIT 11
`define LDCB_INV1_BIT 12
`define LDCB_GATE_BIT 13
`define LDCB_ANA0_BIT 14
`define LDCB_ANA1_BIT 15

// ==========================================
// Scaling constants
`define LDCB_ISET_BASE_UA 17'h01388
`define LDCB_ISET_SPAN_UA 17'h1174C
`define LDCB_ISET_MAX_CODE 17'h0003F
`define LDCB_VDEN_STEP_MV 15'h0273
`define LDCB_OPEN_STEP_MV 15'h004E
`define LDCB_SHORT_STEP_MV 15'h04E2
`define LDCB_PHASE_STEP 10'h020
`define LDCB_WDT_LP_MULT 13'h0003
`define LDCB_ERR_ON 3'h7

`endif

// ===== ldcb_config_bank_chk.sv
// Port-level checker of the configuration bank
`timescale 1ns/1ps
module ldcb_config_bank_chk (
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [15:0] wdata,
   input wire [15:0] rd_data_q,
   input wire rd_valid_q,
   input wire otp_emul_mode,
   input wire otp_write_mode,
   input wire init_mode,
   input wire general_input_1,
   input wire low_power_during_init,
   input wire low_power_active,
   input wire [15:0] phase_delay_enable_n,
   input wire [9:0] phase_step_counts,
   input wire input1_effective,
   input wire last_output_error_pin_en,
   input wire watchdog_enabled,
   input wire [12:0] watchdog_timeout_ms
);
   // ==========================================
   // Helpers
   wire open_w = wr_en && (otp_emul_mode || otp_write_mode);
   wire [4:0] wstep = wdata[8:4];
   wire winv = wdata[12];
   wire [2:0] werr = wdata[15:13];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Assertions
   read_answer_a: assert property (rd_en |=> rd_valid_q)
      else $error("read not answered next cycle");
   read_pulse_a: assert property (!rd_en |=> !rd_valid_q)
      else $error("read valid without request");
   reserved_zero_a: assert property (
      rd_en && addr == 8'h9B |=> !rd_data_q[15])
      else $error("reserved bit read as one");
   out0_phase_a: assert property (!phase_delay_enable_n[0])
      else $error("output 0 phase shifted");
   guard_hold_a: assert property (
      wr_en && !otp_emul_mode && !otp_write_mode
      |=> $stable(phase_delay_enable_n) && $stable(phase_step_counts))
      else $error("protected field changed outside modes");
   phase_step_a: assert property (
      open_w && addr == 8'h9D |=> phase_step_counts == {$past(wstep), 5'h00})
      else $error("phase step not code times 32");
   invert_sel_a: assert property (
      open_w && addr == 8'h9D
      |=> input1_effective == (general_input_1 ^ $past(winv)))
      else $error("second input inversion wrong");
   err_pin_a: assert property (
      open_w && addr == 8'h9E
      |=> last_output_error_pin_en == ($past(werr) == 3'h7))
      else $error("error pin enable wrong");
   low_power_a: assert property (
      low_power_active == (low_power_during_init && init_mode))
      else $error("low power state wrong");
   wdt_triple_a: assert property (
      $rose(init_mode) && low_power_during_init && watchdog_enabled
      && $stable(low_power_during_init) && !$past(wr_en)
      |-> watchdog_timeout_ms == 3 * $past(watchdog_timeout_ms))
      else $error("watchdog not tripled in init");
endmodule

bind ldcb_config_bank ldcb_config_bank_chk u_chk (.clk, .resetn, .wr_en,
   .rd_en, .addr, .wdata, .rd_data_q, .rd_valid_q, .otp_emul_mode,
   .otp_write_mode, .init_mode, .general_input_1, .low_power_during_init,
   .low_power_active, .phase_delay_enable_n, .phase_step_counts,
   .input1_effective, .last_output_error_pin_en, .watchdog_enabled,
   .watchdog_timeout_ms);

// ===== ldcb_config_bank_test.sv
// Self-checking bench of the configuration bank
`timescale 1ns/1ps
`define CHK(n, e, g) \
begin \
   checked++; \
   if ((g) !== (e)) \
   begin \
      miscompares++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, g); \
   end \
end
module ldcb_config_bank_test;
   reg clk, resetn, wr_en, rd_en, otp_emul_mode, otp_write_mode, init_mode;
   reg general_input_0, general_input_1;
   reg [7:0] addr;
   reg [15:0] wdata;
   wire [15:0] rd_data_q, phase_delay_enable_n, adjacent_short_monitor_en;
   wire [15:0] anode_reference_select, channel_input_drive;
   wire [15:0] input0_channel_mask, input1_channel_mask, channel_input_mapped;
   wire [5:0] current_code_ch14, current_code_ch15;
   wire [16:0] current_ch14_ua, current_ch15_ua;
   wire [2:0] diag_filter_count, diag_sample_delay;
   wire [3:0] pwm_base_rate;
   wire [13:0] diag_sample_delay_cycles;
   wire [14:0] diag_enable_thresh_led_mv, open_load_thresh_supply_mv;
   wire input1_duty_decode_en, input1_analog_select, input0_pulldown_en;
   wire [10:0] pwm_base_hz;
   wire [9:0] phase_step_counts, diag_sample_delay_us;
   wire [14:0] diag_enable_thresh_supply_mv, open_load_thresh_led_mv;
   wire [14:0] short_to_led_supply_thresh_mv;
   wire [12:0] watchdog_timeout_ms;
   wire rd_valid_q, low_power_during_init, low_power_active;
   wire input0_duty_decode_en, out0_regulator_feedback_en, input1_effective;
   wire outputs_enabled, input0_analog_select, input1_pulldown_en;
   wire last_output_error_pin_en, watchdog_enabled;
   wire short_to_led_supply_det_en;
   int miscompares = 0, checked = 0, cycles = 0, i;
   int hz[16] = '{100, 200, 240, 300, 360, 400, 540, 600, 660, 720, 780,
      900, 1200, 1500, 1800, 2000};
   int us[8] = '{8, 16, 24, 48, 96, 192, 300, 600};
   int ms[8] = '{0, 20, 50, 100, 200, 500, 1000, 2000};
   logic [15:0] rst[10] = '{16'h1820, 16'hFFFF, 16'h86F3, 16'h09D0,
      16'hFFFF, 16'h2020, 16'hFFFF, 16'h0000, 16'h0000, 16'h0007};
   ldcb_config_bank DUT (.clk, .resetn, .wr_en, .rd_en, .addr, .wdata,
      .rd_data_q, .rd_valid_q, .otp_emul_mode, .otp_write_mode, .init_mode,
      .general_input_0, .general_input_1, .current_code_ch14,
      .current_code_ch15, .current_ch14_ua, .current_ch15_ua,
      .diag_filter_count, .low_power_during_init, .low_power_active,
      .phase_delay_enable_n, .pwm_base_rate, .pwm_base_hz,
      .phase_step_counts, .input0_duty_decode_en, .input1_duty_decode_en,
      .out0_regulator_feedback_en, .input1_effective, .outputs_enabled,
      .input0_analog_select, .input1_analog_select, .input0_pulldown_en,
      .input1_pulldown_en, .diag_enable_thresh_supply_mv,
      .diag_enable_thresh_led_mv, .diag_sample_delay,
      .diag_sample_delay_us, .diag_sample_delay_cycles,
      .last_output_error_pin_en, .adjacent_short_monitor_en,
      .open_load_thresh_supply_mv, .open_load_thresh_led_mv,
      .anode_reference_select, .input0_channel_mask,
      .input1_channel_mask, .channel_input_drive, .channel_input_mapped,
      .watchdog_enabled, .watchdog_timeout_ms, .short_to_led_supply_thresh_mv,
      .short_to_led_supply_det_en);
   // ==========================================
   // Clock, hang guard and bus tasks
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         end_of_test;
      end
   end
   task end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task rd(input [7:0] a, input [15:0] e);
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      `CHK("valid", 1'b1, rd_valid_q)
      `CHK("rdata", e, rd_data_q)
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      {resetn, wr_en, rd_en, otp_emul_mode, otp_write_mode, init_mode} = 0;
      {general_input_0, general_input_1, addr, wdata} = 0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      for (i = 0; i < 10; i++)
         rd(8'(8'h9B + i), rst[i]);
      rd(8'hA5, 16'h0000);
      // Locked writes: only the low power bit may land
      wr(8'h9C, 16'h0000);
      wr(8'h9B, 16'h7FFF);
      rd(8'h9C, 16'hFFFF);
      rd(8'h9B, 16'h5820);
      `CHK("lpi", 1'b1, low_power_during_init)
      `CHK("lpa0", 1'b0, low_power_active)
      otp_write_mode = 1'b1;
      wr(8'h9B, 16'h7FFF);
      rd(8'h9B, 16'h7FFF);
      `CHK("ua", 76500, current_ch14_ua)
      `CHK("code15", 6'h3F, current_code_ch15)
      `CHK("ua15", 76500, current_ch15_ua)
      otp_write_mode = 1'b0;
      otp_emul_mode = 1'b1;
      for (i = 1; i < 4; i++)
      begin
         wr(8'h9B, 16'(i << 12));
         `CHK("dbnc", 2 * i, diag_filter_count)
      end
      `CHK("ua0", 5000, current_ch14_ua)
      `CHK("code14", 6'h00, current_code_ch14)
      `CHK("ua15z", 5000, current_ch15_ua)
      wr(8'h9C, 16'h0003);
      `CHK("phase", 16'h0002, phase_delay_enable_n)
      for (i = 0; i < 16; i++)
      begin
         general_input_0 = i[1];
         general_input_1 = i[2];
         wr(8'h9D, {{7{i[0]}}, 5'(31 - i), i[3:0]});
         `CHK("hz", hz[i], pwm_base_hz)
         `CHK("step", (31 - i) * 32, phase_step_counts)
         `CHK("dec", i[0], input0_duty_decode_en)
         `CHK("fb", i[0], out0_regulator_feedback_en)
         `CHK("inv", i[2] ^ i[0], input1_effective)
         `CHK("gate", !i[0] | i[1], outputs_enabled)
         `CHK("ana", i[0], input0_analog_select)
         `CHK("pd", !i[0], input1_pulldown_en)
         `CHK("rate", i, pwm_base_rate)
         `CHK("dec1", i[0], input1_duty_decode_en)
         `CHK("ana1", i[0], input1_analog_select)
         `CHK("pd0", !i[0], input0_pulldown_en)
      end
      for (i = 0; i < 8; i++)
      begin
         wr(8'h9E, {i[2:0], i[2:0], 5'(31 - i * 4), 5'(i * 4 + 3)});
         `CHK("vl", (31 - i * 4) * 627, diag_enable_thresh_led_mv)
         `CHK("dly", i, diag_sample_delay)
         `CHK("cyc", us[i] * 20, diag_sample_delay_cycles)
         `CHK("us", us[i], diag_sample_delay_us)
         `CHK("err", i == 7, last_output_error_pin_en)
         `CHK("vden", (i * 4 + 3) * 627, diag_enable_thresh_supply_mv)
      end
      wr(8'h9F, 16'h5A3C);
      `CHK("adj", 16'h5A3C, adjacent_short_monitor_en)
      wr(8'hA1, 16'hC3A5);
      `CHK("anode", 16'hC3A5, anode_reference_select)
      wr(8'hA0, 16'hFF01);
      `CHK("sls", 255 * 78, open_load_thresh_led_mv)
      `CHK("sls0", 78, open_load_thresh_supply_mv)
      wr(8'hA2, 16'h00FF);
      wr(8'hA3, 16'h0FF0);
      `CHK("mask0", 16'h00FF, input0_channel_mask)
      `CHK("mask1", 16'h0FF0, input1_channel_mask)
      `CHK("mapped", 16'h0FFF, channel_input_mapped)
      general_input_0 = 1'b1;
      general_input_1 = 1'b0;
      #1 `CHK("map", 16'h0FFF, channel_input_drive)
      @(negedge clk);
      general_input_0 = 1'b0;
      general_input_1 = 1'b1;
      #1 `CHK("map0", 16'h0000, channel_input_drive)
      wr(8'h9B, 16'h4000);
      for (i = 0; i < 8; i++)
      begin
         init_mode = i[0];
         wr(8'hA4, {9'h000, 4'(i * 2), i[2:0]});
         `CHK("wdt", ms[i] * (i[0] ? 3 : 1), watchdog_timeout_ms)
         `CHK("wden", i != 0, watchdog_enabled)
         `CHK("vsh", i * 2500, short_to_led_supply_thresh_mv)
         `CHK("vshen", i != 0, short_to_led_supply_det_en)
         `CHK("lpa", i[0], low_power_active)
      end
      init_mode = 1'b0;
      #1 `CHK("wdt1", 2000, watchdog_timeout_ms)
      @(negedge clk);
      init_mode = 1'b1;
      @(negedge clk);
      end_of_test;
   end
endmodule
